//--- hw/fcss_host.v
// Notes on behaviour
// - Reset may interrupt identity sequence; host writes reset to leave it.
// - Sector erase is two unlocks, 80H, two unlocks, 30H.
// - Extra sector loads start within 50us, else erase begins.
// - Program is two unlocks, set-up command, then address and data.
// - Commands ignored while programming; hardware reset aborts at once; the model's reset leaves busy set, so a running program still completes.
// - After poll bit matches data bit 7 (erase: reads one), host rereads to get full data.
// - Host uses toggle bit or poll bit; the sector toggle bit is never read.
`include "fcss_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module fcss_host (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg [`FCSS_AW-1:0] flash_addr_o,
  output reg [`FCSS_DW-1:0] flash_dq_o,
  output reg flash_dq_oe_o,
  input wire [`FCSS_DW-1:0] flash_dq_i,
  output reg chip_select_n_o,
  output reg write_strobe_n_o,
  output reg output_enable_n_o,
  output reg flash_reset_n_o,
  input wire ready_busy_n_i
);
  localparam S_IDLE = 6'h01;
  localparam S_WRITE = 6'h02;
  localparam S_READ = 6'h04;
  localparam S_POLL = 6'h08;
  localparam S_DONE = 6'h10;
  localparam S_HWRST = 6'h20;
  reg [5:0] state;
  reg [3:0] phase;
  reg [2:0] step;
  reg [2:0] nsteps;
  reg [2:0] op;
  reg [`FCSS_AW-1:0] op_addr;
  reg [`FCSS_DW-1:0] op_data;
  reg [`FCSS_DW-1:0] rd_data;
  reg [`FCSS_DW-1:0] prev_rd;
  reg have_prev;
  reg busy;
  reg ok;
  reg failed;
  reg [15:0] polls;
  reg [2:0] rb_sync;
  reg rb_level;
  wire [`FCSS_DW-1:0] dq_now = flash_dq_i;
  // Unlock pattern, set-up and final codes per command step.
  function [`FCSS_AW+`FCSS_DW-1:0] seq_word;
    input [2:0] o;
    input [2:0] s;
    input [`FCSS_AW-1:0] a;
    input [`FCSS_DW-1:0] d;
    begin
      seq_word = {a, d};
      if (o == `FCSS_OP_RESET) begin
        seq_word = {a, `FCSS_CMD_RESET};
      end else if (o != `FCSS_OP_SECTOR) begin
        case (s)
          3'h0: seq_word = {`FCSS_UNLOCK_ADDR1, `FCSS_UNLOCK_DATA1};
          3'h1: seq_word = {`FCSS_UNLOCK_ADDR2, `FCSS_UNLOCK_DATA2};
          3'h2: begin
            if (o == `FCSS_OP_PROGRAM) begin
              seq_word = {`FCSS_UNLOCK_ADDR1, `FCSS_CMD_PROGRAM};
            end else if (o == `FCSS_OP_ID) begin
              seq_word = {`FCSS_UNLOCK_ADDR1, `FCSS_CMD_ID_READ};
            end else begin
              seq_word = {`FCSS_UNLOCK_ADDR1, `FCSS_CMD_ERASE_SETUP};
            end
          end
          3'h3: begin
            if (o == `FCSS_OP_PROGRAM) begin
              seq_word = {a, d};
            end else begin
              seq_word = {`FCSS_UNLOCK_ADDR1, `FCSS_UNLOCK_DATA1};
            end
          end
          3'h4: seq_word = {`FCSS_UNLOCK_ADDR2, `FCSS_UNLOCK_DATA2};
          default: seq_word = {a, `FCSS_CMD_SECTOR_ERASE};
        endcase
      end else begin
        seq_word = {a, `FCSS_CMD_SECTOR_ERASE};
      end
    end
  endfunction
  wire [`FCSS_AW+`FCSS_DW-1:0] cur_word = seq_word(op, step, op_addr, op_data);
  // Three stages on the pin; a change counts when stages two and three agree.
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rb_sync <= 3'h7;
      rb_level <= 1'b1;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_n_i};
      if (rb_sync[2] == rb_sync[1]) begin
        rb_level <= rb_sync[2];
      end
    end
  end
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= S_IDLE;
      phase <= 4'h0;
      step <= 3'h0;
      nsteps <= 3'h0;
      op <= 3'h0;
      op_addr <= {`FCSS_AW{1'b0}};
      op_data <= {`FCSS_DW{1'b0}};
      rd_data <= {`FCSS_DW{1'b0}};
      prev_rd <= {`FCSS_DW{1'b0}};
      have_prev <= 1'b0;
      busy <= 1'b0;
      ok <= 1'b0;
      failed <= 1'b0;
      polls <= 16'h0000;
      rdata_o <= 32'h00000000;
      flash_addr_o <= {`FCSS_AW{1'b0}};
      flash_dq_o <= {`FCSS_DW{1'b0}};
      flash_dq_oe_o <= 1'b0;
      chip_select_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      flash_reset_n_o <= 1'b1;
    end else begin
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `FCSS_REG_ADDR: rdata_o <= {{(32-`FCSS_AW){1'b0}}, op_addr};
          `FCSS_REG_DATA: rdata_o <= {16'h0000, op_data};
          `FCSS_REG_STATUS: rdata_o <= {27'h0, rb_level, failed, ok, busy, state == S_IDLE};
          `FCSS_REG_RDATA: rdata_o <= {16'h0000, rd_data};
          default: rdata_o <= 32'h00000000;
        endcase
      end
      if (wr_i && addr_i == `FCSS_REG_ADDR) begin
        op_addr <= wdata_i[`FCSS_AW-1:0];
      end
      if (wr_i && addr_i == `FCSS_REG_DATA) begin
        op_data <= wdata_i[`FCSS_DW-1:0];
      end
      case (state)
        S_IDLE: begin
          if (wr_i && addr_i == `FCSS_REG_CTRL && wdata_i[2:0] != 3'h0) begin
            op <= wdata_i[2:0];
            step <= 3'h0;
            phase <= 4'h0;
            ok <= 1'b0;
            failed <= 1'b0;
            busy <= 1'b1;
            have_prev <= 1'b0;
            polls <= 16'h0000;
            case (wdata_i[2:0])
              `FCSS_OP_RESET: begin
                nsteps <= 3'h0;
                state <= S_WRITE;
              end
              `FCSS_OP_SECTOR: begin
                nsteps <= 3'h0;
                state <= S_WRITE;
              end
              `FCSS_OP_PROGRAM: begin
                nsteps <= 3'h3;
                state <= S_WRITE;
              end
              `FCSS_OP_ID: begin
                nsteps <= 3'h2;
                state <= S_WRITE;
              end
              `FCSS_OP_ERASE: begin
                nsteps <= 3'h5;
                state <= S_WRITE;
              end
              `FCSS_OP_READ: state <= S_READ;
              default: state <= S_HWRST;
            endcase
          end
        end
        // Address set in the same cycle the strobes fall, data held past their rise.
        S_WRITE: begin
          phase <= phase + 4'h1;
          if (phase == 4'h0) begin
            flash_addr_o <= cur_word[`FCSS_AW+`FCSS_DW-1:`FCSS_DW];
            flash_dq_o <= cur_word[`FCSS_DW-1:0];
            flash_dq_oe_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            chip_select_n_o <= 1'b0;
            write_strobe_n_o <= 1'b0;
          end else if (phase == `FCSS_PHASE_CYC) begin
            write_strobe_n_o <= 1'b1;
            chip_select_n_o <= 1'b1;
          end else if (phase == `FCSS_PHASE_CYC + 4'h1) begin
            flash_dq_oe_o <= 1'b0;
            phase <= 4'h0;
            if (step == nsteps) begin
              if (op == `FCSS_OP_PROGRAM || op == `FCSS_OP_ERASE) begin
                state <= S_POLL;
              end else begin
                state <= S_DONE;
              end
            end else begin
              step <= step + 3'h1;
            end
          end
        end
        S_READ, S_POLL: begin
          phase <= phase + 4'h1;
          if (phase == 4'h0) begin
            flash_addr_o <= op_addr;
            chip_select_n_o <= 1'b0;
            output_enable_n_o <= 1'b0;
          end else if (phase == `FCSS_PHASE_CYC) begin
            // The older sample is kept, so two reads in a row can be compared.
            rd_data <= dq_now;
            prev_rd <= rd_data;
            output_enable_n_o <= 1'b1;
            chip_select_n_o <= 1'b1;
          end else if (phase == `FCSS_PHASE_CYC + 4'h1) begin
            phase <= 4'h0;
            polls <= polls + 16'h0001;
            have_prev <= 1'b1;
            if (state == S_READ) begin
              state <= S_DONE;
            end else if (have_prev && prev_rd[`FCSS_BIT_TOGGLE] == rd_data[`FCSS_BIT_TOGGLE]) begin
              op <= `FCSS_OP_READ;
              state <= S_READ;
            end else if (op == `FCSS_OP_PROGRAM
                && rd_data[`FCSS_BIT_POLL] == op_data[`FCSS_BIT_POLL]) begin
              op <= `FCSS_OP_READ;
              state <= S_READ;
            end else if (op == `FCSS_OP_ERASE && rd_data[`FCSS_BIT_POLL]) begin
              op <= `FCSS_OP_READ;
              state <= S_READ;
            end else if ((have_prev && rd_data[`FCSS_BIT_TIMEOUT] && prev_rd[`FCSS_BIT_TIMEOUT])
                || polls == `FCSS_MAX_POLLS) begin
              // Timeout bit on two reads in a row, or poll limit: mark failed and send reset.
              failed <= 1'b1;
              op <= `FCSS_OP_RESET;
              step <= 3'h0;
              nsteps <= 3'h0;
              state <= S_WRITE;
            end
          end
        end
        S_HWRST: begin
          phase <= phase + 4'h1;
          flash_reset_n_o <= 1'b0;
          if (phase == `FCSS_PHASE_CYC) begin
            flash_reset_n_o <= 1'b1;
            phase <= 4'h0;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          busy <= 1'b0;
          ok <= ~failed;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fcss_host
`default_nettype wire

//--- inc/fcss_defines.vh
`ifndef FCSS_DEFINES_VH
`define FCSS_DEFINES_VH
`define FCSS_AW 20
`define FCSS_DW 16
`define FCSS_UNLOCK_ADDR1 20'h00555
`define FCSS_UNLOCK_DATA1 16'h00AA
`define FCSS_UNLOCK_ADDR2 20'h002AA
`define FCSS_UNLOCK_DATA2 16'h0055
`define FCSS_CMD_RESET 16'h00F0
`define FCSS_CMD_ERASE_SETUP 16'h0080
`define FCSS_CMD_SECTOR_ERASE 16'h0030
`define FCSS_CMD_PROGRAM 16'h00A0
`define FCSS_CMD_ID_READ 16'h0090
`define FCSS_BIT_POLL 7
`define FCSS_BIT_TOGGLE 6
`define FCSS_BIT_TIMEOUT 5
`define FCSS_BIT_WINDOW 3
`define FCSS_REG_CTRL 4'h0
`define FCSS_REG_ADDR 4'h1
`define FCSS_REG_DATA 4'h2
`define FCSS_REG_STATUS 4'h3
`define FCSS_REG_RDATA 4'h4
`define FCSS_OP_RESET 3'h1
`define FCSS_OP_PROGRAM 3'h2
`define FCSS_OP_ERASE 3'h3
`define FCSS_OP_READ 3'h4
`define FCSS_OP_SECTOR 3'h5
`define FCSS_OP_ID 3'h6
`define FCSS_PHASE_CYC 4'h3
`define FCSS_MAX_POLLS 16'hFFFF
`endif

//--- sim/fcss_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcss_defines.vh"
module fcss_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h1234 // Arbitrary value.
) (
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic rst_n_i,
  output logic ready_busy_n_o
);
  logic [15:0] mem [0:15];
  logic [19:0] la;
  logic [15:0] pd, last;
  logic [1:0] st;
  logic ers, id, busy, prg, win, tog, to;
  realtime wt;
  wire wl = !cs_n_i && !we_n_i;
  wire rl = !cs_n_i && !oe_n_i;
  wire [15:0] stat = {8'h0, prg ? ~pd[7] : 1'b0, tog, to, 1'b0, busy & !prg, tog & !prg, 2'h0};
  wire [15:0] val = (busy || win) ? stat : id ? ID_CODE : mem[addr_i[3:0]];
  // A released bus shows the inverse, so a stale sample cannot pass.
  assign dq_o = rl ? val : ~last;
  assign ready_busy_n_o = !(busy || win);
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    {st, ers, id, busy, prg, win, tog, to, last, la} = 0;
  end
  always @(negedge rl) begin
    last = val;
    tog ^= busy || win;
  end
  always @(negedge rst_n_i) {st, id, ers, win, to} = 0;
  // A stuck operation only leaves on the reset command.
  always @(negedge wl) if (to && dq_i == `FCSS_CMD_RESET) {st, busy, prg, to} = 0;
  always @(posedge wl) la = addr_i;
  always @(negedge wl) if (!busy) begin
    if (win) win = dq_i == `FCSS_CMD_SECTOR_ERASE;
    if (win) wt = $realtime;
    else if (dq_i == `FCSS_CMD_RESET) {st, id, ers} = 0;
    else case (st)
      0: st = {1'b0, la == `FCSS_UNLOCK_ADDR1 && dq_i == `FCSS_UNLOCK_DATA1};
      1: st = {la == `FCSS_UNLOCK_ADDR2 && dq_i == `FCSS_UNLOCK_DATA2, 1'b0};
      2: begin
        win = ers && dq_i == `FCSS_CMD_SECTOR_ERASE;
        wt = $realtime;
        ers = !ers && dq_i == `FCSS_CMD_ERASE_SETUP;
        id = dq_i == `FCSS_CMD_ID_READ;
        st = dq_i == `FCSS_CMD_PROGRAM ? 2'h3 : 2'h0;
      end
      default: begin
        {st, busy, prg, pd} = {4'h3, dq_i};
        #2000;
        to = |(pd & ~mem[la[3:0]]);
        mem[la[3:0]] &= pd;
        {st, busy, prg} = {2'h0, to, to};
      end
    endcase
  end
  always #1000 if (win && $realtime - wt > 50000) begin
    {win, busy} = 2'h1;
    #5000;
    for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    busy = 0;
  end
endmodule // fcss_flash_model
`default_nettype wire

//--- sim/fcss_props.sv
`timescale 1ns/1ps
`default_nettype none
module fcss_props (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [19:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic chip_select_n_o,
  input wire logic write_strobe_n_o,
  input wire logic output_enable_n_o,
  input wire logic flash_reset_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  rdata_slot_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside slot");
  write_pulse_a: assert property ($fell(write_strobe_n_o) |->
    (!write_strobe_n_o) [*3] ##[1:3] write_strobe_n_o) else $error("write pulse");
  write_form_a: assert property (!write_strobe_n_o |->
    !chip_select_n_o && output_enable_n_o && flash_dq_oe_o) else $error("write form");
  no_contend_a: assert property (flash_dq_oe_o |-> output_enable_n_o)
    else $error("bus contention");
  addr_hold_a: assert property (!write_strobe_n_o && !$past(write_strobe_n_o) |->
    $stable(flash_addr_o) && $stable(flash_dq_o)) else $error("addr moved");
  data_hold_a: assert property ($rose(write_strobe_n_o) |->
    flash_dq_oe_o ##[1:2] !flash_dq_oe_o) else $error("data hold");
  read_pulse_a: assert property ($fell(output_enable_n_o) |->
    (!output_enable_n_o && !chip_select_n_o) [*3]) else $error("read pulse");
  hw_reset_a: assert property (!flash_reset_n_o |->
    write_strobe_n_o && chip_select_n_o) else $error("access in reset");
  cover property ($fell(write_strobe_n_o));
  cover property ($fell(output_enable_n_o));
  cover property ($fell(flash_reset_n_o));
endmodule // fcss_props
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcss_defines.vh"
module testbench;
  logic ref_clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, ck = 0, ck2 = 0;
  logic [3:0] addr_i = 0;
  logic [31:0] wdata_i = 0, v, d1, d2, seed = 32'h8E85900A;
  logic [31:0] q [$];
  int n_fail = 0, num_checks = 0;
  wire [31:0] rdata_o;
  wire [19:0] fa;
  wire oe, cs_n, we_n, oe_n, rst_n, rb_n;
  wire [15:0] fdo, mdo;
  wire [15:0] dq = oe ? fdo : mdo;
  always #10 ref_clk_i = !ref_clk_i;
  fcss_host dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flash_addr_o(fa), .flash_dq_o(fdo),
    .flash_dq_oe_o(oe), .flash_dq_i(dq), .chip_select_n_o(cs_n), .write_strobe_n_o(we_n),
    .output_enable_n_o(oe_n), .flash_reset_n_o(rst_n), .ready_busy_n_i(rb_n));
  fcss_flash_model flash (.addr_i(fa), .dq_i(dq), .dq_o(mdo), .cs_n_i(cs_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .rst_n_i(rst_n), .ready_busy_n_o(rb_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk_i) begin
    if (ck2) chk(rdata_o, q.pop_front());
    ck2 <= ck;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic c, input logic [31:0] e);
    if (c) q.push_back(e);
    @(posedge ref_clk_i);
    {rd_i, addr_i, ck} <= {1'b1, a, c};
    @(posedge ref_clk_i);
    {rd_i, ck} <= 2'h0;
    #1 v = rdata_o;
  endtask
  // Polling is bounded; a hung operation ends the run as a failure.
  task automatic idle;
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 30000; i++) begin
      rd(`FCSS_REG_STATUS, 0, 0);
      if (v[0] === 1'b1 && v[1] === 1'b0) return;
    end
    n_fail++;
    end_of_test;
  endtask
  task automatic op(input logic [2:0] o, input logic [31:0] d);
    wr(`FCSS_REG_ADDR, 32'h3);
    wr(`FCSS_REG_DATA, d);
    wr(`FCSS_REG_CTRL, {29'h0, o});
    idle;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 0;
    repeat (8) @(posedge ref_clk_i);
    rd(`FCSS_REG_STATUS, 1, 32'h11);
    for (int a = 5; a < 16; a++) rd(a[3:0], 1, 32'h0);
    seed = xs(seed);
    d1 = {16'h0, seed[15:0]};
    seed = xs(seed);
    d2 = {16'h0, seed[15:0]};
    op(`FCSS_OP_PROGRAM, d1);
    rd(`FCSS_REG_STATUS, 1, 32'h15);
    rd(`FCSS_REG_RDATA, 1, d1);
    op(`FCSS_OP_PROGRAM, d2);
    rd(`FCSS_REG_STATUS, 1, ((d2 & ~d1) != 0) ? 32'h19 : 32'h15);
    op(`FCSS_OP_READ, 0);
    rd(`FCSS_REG_RDATA, 1, d1 & d2);
    op(`FCSS_OP_ID, 0);
    op(`FCSS_OP_READ, 0);
    rd(`FCSS_REG_RDATA, 1, 32'h1234);
    op(`FCSS_OP_RESET, 0);
    op(`FCSS_OP_READ, 0);
    rd(`FCSS_REG_RDATA, 1, d1 & d2);
    wr(`FCSS_REG_CTRL, {29'h0, `FCSS_OP_ERASE});
    op(`FCSS_OP_SECTOR, 0);
    op(`FCSS_OP_READ, 0);
    rd(`FCSS_REG_RDATA, 1, 32'hFFFF);
    op(3'h7, 0);
    rd(`FCSS_REG_STATUS, 1, 32'h15);
    // The last queued compare runs a cycle later, so let it happen first.
    repeat (3) @(posedge ref_clk_i);
    end_of_test;
  end
endmodule // testbench
bind fcss_host fcss_props u_props (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o), .chip_select_n_o(chip_select_n_o),
  .write_strobe_n_o(write_strobe_n_o), .output_enable_n_o(output_enable_n_o),
  .flash_reset_n_o(flash_reset_n_o));
`default_nettype wire
